// file: rtl/fcep_flash.sv
// Serial flash command logic for whole-array erase and byte/page program
`timescale 1ns/1ps
`default_nettype none
module fcep_flash
#(
	parameter int unsigned PAGE_PROG_CYCLES  = fcep_pkg::PAGE_PROGRAM_CYCLES,
	parameter int unsigned BYTE_PROG_CYCLES  = fcep_pkg::BYTE_PROGRAM_CYCLES,
	parameter int unsigned CHIP_ERASE_CYCLES = fcep_pkg::CHIP_ERASE_CYCLES
)
(
	input  wire logic                       core_clk_in,
	input  wire logic                       rstn_in,
	input  wire logic                       spi_cs_n_in,
	input  wire logic                       spi_sclk_in,
	input  wire logic                       spi_si_in,
	output logic                            spi_so_out,
	output logic                            spi_so_oe_out,
	input  wire logic                       any_block_protected_in,
	input  wire logic                       target_protected_in,
	output logic                     [23:0] program_addr_out,
	input  wire logic                       array_fail_in,
	output logic                            array_erase_out,
	output logic                            array_wr_valid_out,
	input  wire logic                       array_wr_ready_in,
	output fcep_pkg::fcep_wr_word_type      array_wr_word_out,
	input  wire logic                       clear_errors_in,
	output logic                            ready_busy_flag_out,
	output logic                            write_enable_latch_out,
	output logic                            erase_error_flag_out,
	output logic                            program_error_flag_out
);
	fcep_pkg::fcep_core_type    q;
	fcep_pkg::fcep_core_type    d;
	logic [7:0]                 page_buf [256];
	logic                       buf_we;
	logic [7:0]                 buf_waddr;
	logic [7:0]                 buf_wdata;
	logic                       push_valid;
	fcep_pkg::fcep_wr_word_type push_word;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic [7:0]                 byte_val;
	logic [7:0]                 sr1;
	logic                       busy;
	logic                       cs_active;
	logic                       cs_fall;
	logic                       cs_rise;
	logic                       sck_rise;
	logic                       sck_fall;

	function automatic logic is_chip_erase(input logic [7:0] op);
		is_chip_erase = (op == fcep_pkg::OP_CHIP_ERASE_A) || (op == fcep_pkg::OP_CHIP_ERASE_B);
	endfunction : is_chip_erase

	function automatic logic is_status_op(input logic [7:0] op);
		is_status_op = (op == fcep_pkg::OP_READ_STATUS_ONE) || (op == fcep_pkg::OP_ACTIVE_STATUS);
	endfunction : is_status_op

	// Only the second and third sync stages feed edge logic
	assign cs_active = ~q.cs_sync[1];
	assign cs_fall   = ~q.cs_sync[1] & q.cs_sync[2];
	assign cs_rise   = q.cs_sync[1] & ~q.cs_sync[2];
	assign sck_rise  = q.sck_sync[1] & ~q.sck_sync[2];
	assign sck_fall  = ~q.sck_sync[1] & q.sck_sync[2];
	assign busy      = ~q.st[0];
	assign byte_val  = {q.shift, q.si_sync[1]};

	// RQ14: busy in bit zero
	always_comb
	begin
		sr1                                = 8'h00;
		sr1[fcep_pkg::SR1_BUSY_BIT]        = busy;
		sr1[fcep_pkg::SR1_WEL_BIT]         = q.write_enable_latch;
	end

	assign push_word.addr = {q.addr[23:8], q.idx[7:0]};
	assign push_word.data = page_buf[q.idx[7:0]];

	always_comb
	begin
		d          = q;
		buf_we     = 1'b0;
		buf_waddr  = q.lo;
		buf_wdata  = byte_val;
		push_valid = 1'b0;
		d.cs_sync  = {q.cs_sync[1:0], spi_cs_n_in};
		d.sck_sync = {q.sck_sync[1:0], spi_sclk_in};
		d.si_sync  = {q.si_sync[0], spi_si_in};

		if (clear_errors_in)
		begin
			d.ee = 1'b0;
			d.pe = 1'b0;
		end

		if (cs_fall)
		begin
			d.bits   = 3'h0;
			d.nbytes = 3'h0;
			d.opcode = fcep_pkg::OP_NONE;
		end
		// RQ11: MSB-first shift on sclk rise
		else if (cs_active && sck_rise)
		begin
			d.shift = byte_val[6:0];
			d.bits  = q.bits + 3'h1;
			if (q.bits == fcep_pkg::LAST_BIT)
			begin
				if (q.nbytes != fcep_pkg::BYTES_FIRST_DATA)
				begin
					d.nbytes = q.nbytes + 3'h1;
				end
				if (q.nbytes == 3'h0)
				begin
					// Commands other than status and suspend are dropped while busy
					if (!busy || is_status_op(byte_val) || (byte_val == fcep_pkg::OP_SUSPEND))
					begin
						d.opcode = byte_val;
					end
					else
					begin
						d.opcode = fcep_pkg::OP_NONE;
					end
					if (!busy && (byte_val == fcep_pkg::OP_PAGE_PROGRAM))
					begin
						d.valid = '0;
						d.count = 9'h000;
					end
				end
				else if (q.opcode == fcep_pkg::OP_PAGE_PROGRAM)
				begin
					if (q.nbytes <= fcep_pkg::BYTES_LAST_ADDR)
					begin
						d.addr = {q.addr[15:0], byte_val};
						if (q.nbytes == fcep_pkg::BYTES_LAST_ADDR)
						begin
							d.lo = byte_val;
						end
					end
					else
					begin
						// RQ17: low address byte wraps in page
						// RQ18: later bytes overwrite, last 256 kept
						buf_we          = 1'b1;
						d.valid[q.lo]   = 1'b1;
						d.lo            = q.lo + 8'h01;
						// RQ9: one to 256 bytes counted
						if (q.count != fcep_pkg::PAGE_BYTES)
						begin
							d.count = q.count + fcep_pkg::ONE_BYTE;
						end
					end
				end
			end
		end

		// Status register one shifted out on sclk fall
		if (cs_active && sck_fall && (q.nbytes != 3'h0) && (q.opcode == fcep_pkg::OP_READ_STATUS_ONE))
		begin
			d.so = sr1[fcep_pkg::LAST_BIT - q.bits];
		end
		// RQ4: busy flag refreshed continuously
		if (cs_active && (q.nbytes != 3'h0) && (q.opcode == fcep_pkg::OP_ACTIVE_STATUS))
		begin
			d.so = busy;
		end
		d.so_oe = cs_active && (q.nbytes != 3'h0) && is_status_op(q.opcode);

		// Array engine
		case (q.st)
			fcep_pkg::FCEP_IDLE:
			begin
				d.idx = 9'h100;
			end
			fcep_pkg::FCEP_PROG:
			begin
				if (q.timer != 32'h0)
				begin
					d.timer = q.timer - 32'h1;
				end
				// RQ12: only supplied locations are written
				if (!q.idx[8])
				begin
					if (!q.valid[q.idx[7:0]])
					begin
						d.idx = q.idx + 9'h001;
					end
					else if (fifo_in_ready)
					begin
						push_valid = 1'b1;
						d.idx      = q.idx + 9'h001;
					end
				end
				// RQ20: program failure flag
				if (array_fail_in)
				begin
					d.pe = 1'b1;
				end
				if (q.idx[8] && (q.timer == 32'h0) && !fifo_out_valid)
				begin
					d.st  = fcep_pkg::FCEP_IDLE;
					d.write_enable_latch = 1'b0;
				end
			end
			fcep_pkg::FCEP_ERASE:
			begin
				if (q.timer != 32'h0)
				begin
					d.timer = q.timer - 32'h1;
				end
				// RQ8: erase failure sets both flags
				if (array_fail_in)
				begin
					d.ee = 1'b1;
					d.pe = 1'b1;
				end
				if (q.timer == 32'h0)
				begin
					d.st = fcep_pkg::FCEP_IDLE;
				end
			end
			default:
			begin
				d.st = fcep_pkg::FCEP_IDLE;
			end
		endcase

		// End of frame: decide what the finished command does
		if (cs_rise)
		begin
			d.so_oe = 1'b0;
			if ((q.opcode == fcep_pkg::OP_WRITE_ENABLE) && (q.bits == 3'h0)
				&& (q.nbytes == fcep_pkg::BYTES_OPCODE_ONLY))
			begin
				d.write_enable_latch = 1'b1;
			end
			else if ((q.opcode == fcep_pkg::OP_WRITE_DISABLE) && (q.bits == 3'h0)
				&& (q.nbytes == fcep_pkg::BYTES_OPCODE_ONLY))
			begin
				d.write_enable_latch = 1'b0;
			end
			// RQ1: both erase opcodes alike
			else if (is_chip_erase(q.opcode))
			begin
				// RQ5: off-boundary release aborts erase
				if (q.bits != 3'h0)
				begin
					d.write_enable_latch = 1'b0;
				end
				// RQ6: protected blocks refuse erase
				else if (any_block_protected_in)
				begin
					d.write_enable_latch = 1'b0;
				end
				// RQ2: erase needs the latch
				else if (q.write_enable_latch)
				begin
					// RQ3: latch cleared as erase starts
					d.write_enable_latch   = 1'b0;
					d.st    = fcep_pkg::FCEP_ERASE;
					d.timer = 32'(CHIP_ERASE_CYCLES);
				end
			end
			else if (q.opcode == fcep_pkg::OP_PAGE_PROGRAM)
			begin
				// RQ15: off-boundary release aborts program
				// RQ19: partial address or data aborts
				if ((q.bits != 3'h0) || (q.nbytes < fcep_pkg::BYTES_FIRST_DATA))
				begin
					d.write_enable_latch = 1'b0;
				end
				// RQ16: protected target refused
				else if (target_protected_in)
				begin
					d.write_enable_latch = 1'b0;
				end
				// RQ10: program needs the latch
				// RQ13: self-timed page or byte time
				else if (q.write_enable_latch)
				begin
					d.st    = fcep_pkg::FCEP_PROG;
					d.idx   = 9'h000;
					d.timer = (q.count == fcep_pkg::ONE_BYTE) ? 32'(BYTE_PROG_CYCLES) : 32'(PAGE_PROG_CYCLES);
				end
			end
			// RQ7: suspend has no effect on erase
			else if (q.opcode == fcep_pkg::OP_SUSPEND)
			begin
				d.write_enable_latch = q.write_enable_latch;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			q         <= '0;
			q.st      <= fcep_pkg::FCEP_IDLE;
			q.cs_sync <= fcep_pkg::CS_SYNC_RESET;
			q.idx     <= fcep_pkg::PAGE_BYTES;
		end
		else
		begin
			q <= d;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (buf_we)
		begin
			page_buf[buf_waddr] <= buf_wdata;
		end
	end

	// RQ21: array sees writes only from an accepted program
	fcep_fifo
	#(
		.WIDTH (fcep_pkg::WR_WORD_BITS),
		.DEPTH (fcep_pkg::FIFO_DEPTH)
	)
	u_wr_fifo
	(
		.core_clk_in   (core_clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (push_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (push_word),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (array_wr_ready_in),
		.out_data_out  (array_wr_word_out)
	);

	assign array_wr_valid_out     = fifo_out_valid;
	assign array_erase_out        = q.st[2];
	assign ready_busy_flag_out    = busy;
	assign write_enable_latch_out = q.write_enable_latch;
	assign erase_error_flag_out   = q.ee;
	assign program_error_flag_out = q.pe;
	assign program_addr_out       = q.addr;
	assign spi_so_out             = q.so;
	assign spi_so_oe_out          = q.so_oe;

endmodule : fcep_flash
`default_nettype wire

// file: inc/fcep_pkg.sv
// Constants, types and state layout for the serial flash erase/program command block
// Functional notes
// RQ1: Opcodes 60h and C7h both erase the whole array once chip select rises.
// RQ2: Whole-array erase runs only when the write enable latch is set.
// RQ3: Write enable latch clears before a whole-array erase finishes.
// RQ4: Active status command drives the ready/busy flag onto serial out continuously.
// RQ5: Erase ending off a byte boundary aborts without erasing and clears the latch.
// RQ6: Any protected block refuses whole-array erase and clears the latch.
// RQ7: Suspend command is ignored while a whole-array erase runs.
// RQ8: Failed erase location sets both erase and program error flags.
// RQ9: Program writes 1 to 256 bytes into erased locations.
// RQ10: Program runs only when the write enable latch is set.
// RQ11: Program frame is 8-bit opcode, 24-bit address, data bytes, MSB first.
// RQ12: Page locations not supplied are left untouched, keeping erased value.
// RQ13: Valid program moves buffer to array, self-timed for page or byte time.
// RQ14: Ready/busy flag is bit zero of status register one while busy.
// RQ15: Program ending off a byte boundary aborts, programs nothing, clears the latch.
// RQ16: Protected target refuses program, returns idle, clears the latch.
// RQ17: Only the low eight address bits advance, wrapping within the page.
// RQ18: More than 256 data bytes leaves only the final 256 buffered.
// RQ19: Partial address or partial data byte aborts program and clears the latch.
// RQ20: Failed program location sets the program error flag.
// RQ21: Aborted or refused commands leave the array completely unchanged.
package fcep_pkg;

	localparam logic [7:0] OP_NONE            = 8'h00;
	localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
	localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OP_ACTIVE_STATUS   = 8'h25;
	localparam logic [7:0] OP_CHIP_ERASE_A    = 8'h60;
	localparam logic [7:0] OP_SUSPEND         = 8'h75;
	localparam logic [7:0] OP_CHIP_ERASE_B    = 8'hC7;

	localparam logic [2:0] BYTES_OPCODE_ONLY  = 3'h1;
	localparam logic [2:0] BYTES_LAST_ADDR    = 3'h3;
	localparam logic [2:0] BYTES_FIRST_DATA   = 3'h5;
	localparam logic [2:0] LAST_BIT           = 3'h7;
	localparam logic [8:0] PAGE_BYTES         = 9'h100;
	localparam logic [8:0] ONE_BYTE           = 9'h001;

	localparam int unsigned SR1_BUSY_BIT      = 0;
	localparam int unsigned SR1_WEL_BIT       = 1;

	localparam int unsigned CORE_CLK_MHZ          = 100;
	localparam int unsigned PAGE_PROGRAM_TIME_US  = 1000;
	localparam int unsigned BYTE_PROGRAM_TIME_US  = 100;
	localparam int unsigned CHIP_ERASE_TIME_MS    = 20;
	localparam int unsigned PAGE_PROGRAM_CYCLES   = PAGE_PROGRAM_TIME_US * CORE_CLK_MHZ;
	localparam int unsigned BYTE_PROGRAM_CYCLES   = BYTE_PROGRAM_TIME_US * CORE_CLK_MHZ;
	localparam int unsigned CHIP_ERASE_CYCLES     = CHIP_ERASE_TIME_MS * 1000 * CORE_CLK_MHZ;

	localparam int unsigned FIFO_DEPTH        = 16;
	localparam logic [2:0]  CS_SYNC_RESET     = 3'h7;

	typedef enum logic [2:0]
	{
		FCEP_IDLE  = 3'b001,
		FCEP_PROG  = 3'b010,
		FCEP_ERASE = 3'b100
	} fcep_state_type;

	typedef struct packed
	{
		logic [23:0] addr;
		logic [7:0]  data;
	} fcep_wr_word_type;

	localparam int unsigned WR_WORD_BITS = $bits(fcep_wr_word_type);

	typedef struct packed
	{
		fcep_state_type st;
		logic [2:0]     cs_sync;
		logic [2:0]     sck_sync;
		logic [1:0]     si_sync;
		logic [2:0]     bits;
		logic [2:0]     nbytes;
		logic [6:0]     shift;
		logic [7:0]     opcode;
		logic [23:0]    addr;
		logic [7:0]     lo;
		logic [8:0]     count;
		logic [255:0]   valid;
		logic [8:0]     idx;
		logic [31:0]    timer;
		logic           write_enable_latch;
		logic           ee;
		logic           pe;
		logic           so;
		logic           so_oe;
	} fcep_core_type;

endpackage : fcep_pkg

// file: rtl/fcep_fifo.sv
// Parameterised valid/ready FIFO between page buffer and array write port
`timescale 1ns/1ps
`default_nettype none
module fcep_fifo
#(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16
)
(
	input  wire logic             core_clk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} fcep_fifo_state_type;

	fcep_fifo_state_type q;
	fcep_fifo_state_type d;
	logic [WIDTH-1:0]    mem [DEPTH];
	logic                push;
	logic                pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction : next_ptr

	assign in_ready_out  = (q.cnt != (AW + 1)'(DEPTH));
	assign out_valid_out = (q.cnt != '0);
	assign out_data_out  = mem[q.rd];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	always_comb
	begin
		d = q;
		if (push)
		begin
			d.wr = next_ptr(q.wr);
		end
		if (pop)
		begin
			d.rd = next_ptr(q.rd);
		end
		if (push && !pop)
		begin
			d.cnt = q.cnt + (AW + 1)'(1);
		end
		else if (pop && !push)
		begin
			d.cnt = q.cnt - (AW + 1)'(1);
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (push)
		begin
			mem[q.wr] <= in_data_in;
		end
	end

endmodule : fcep_fifo
`default_nettype wire

// file: verif/fcep_flash_chk.sv
// Concurrent checks on the ports of the flash erase/program block
`timescale 1ns/1ps
`default_nettype none
module fcep_flash_chk
#(
	parameter int unsigned CHIP_ERASE_CYCLES = 50
)
(
	input wire logic                       core_clk_in,
	input wire logic                       rstn_in,
	input wire logic                       spi_cs_n_in,
	input wire logic                       spi_so_oe_out,
	input wire logic                [23:0] program_addr_out,
	input wire logic                       array_fail_in,
	input wire logic                       array_erase_out,
	input wire logic                       array_wr_valid_out,
	input wire logic                       array_wr_ready_in,
	input wire fcep_pkg::fcep_wr_word_type array_wr_word_out,
	input wire logic                       ready_busy_flag_out,
	input wire logic                       write_enable_latch_out,
	input wire logic                       erase_error_flag_out,
	input wire logic                       program_error_flag_out
);
	logic [31:0] erase_len_q;
	logic [31:0] erase_len_d;

	// Counts cycles of the running erase
	always_comb
		erase_len_d = array_erase_out ? erase_len_q + 32'h1 : 32'h0;
	always_ff @(posedge core_clk_in or negedge rstn_in)
		if (!rstn_in)
			erase_len_q <= 32'h0;
		else
			erase_len_q <= erase_len_d;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	AST_ERASE_LENGTH: assert property ($fell(array_erase_out) |-> erase_len_q == CHIP_ERASE_CYCLES + 1)
		else $error("erase length differs from the configured count");
	AST_ERASE_START_LATCH: assert property ($rose(array_erase_out) |-> ready_busy_flag_out && !write_enable_latch_out)
		else $error("erase started without busy or with latch set");
	AST_ERASE_BUSY: assert property (array_erase_out |-> ready_busy_flag_out)
		else $error("erase running while not busy");
	AST_DONE_CLEAN: assert property ($fell(ready_busy_flag_out) |-> !array_wr_valid_out && !write_enable_latch_out)
		else $error("busy ended with words pending or latch set");
	AST_WRITE_ONLY_BUSY: assert property (array_wr_valid_out |-> ready_busy_flag_out)
		else $error("array write offered while idle");
	AST_WRITE_HELD: assert property (array_wr_valid_out && !array_wr_ready_in |=> array_wr_valid_out && $stable(array_wr_word_out))
		else $error("array write changed while stalled");
	AST_WRITE_IN_PAGE: assert property (array_wr_valid_out |-> array_wr_word_out.addr[23:8] == program_addr_out[23:8])
		else $error("array write left the addressed page");
	AST_PROG_FAIL: assert property (ready_busy_flag_out && !array_erase_out && array_fail_in |=> program_error_flag_out)
		else $error("program failure not flagged");
	AST_ERASE_FAIL: assert property (array_erase_out && array_fail_in |=> erase_error_flag_out && program_error_flag_out)
		else $error("erase failure not flagged on both flags");
	AST_SO_RELEASED: assert property (spi_cs_n_in [*8] |-> !spi_so_oe_out)
		else $error("serial out still driven while deselected");

	COV_ERASE: cover property ($rose(array_erase_out));
	COV_WRITE: cover property (array_wr_valid_out && array_wr_ready_in);
	COV_STALL: cover property (array_wr_valid_out && !array_wr_ready_in);
	COV_DONE: cover property ($fell(ready_busy_flag_out));
endmodule : fcep_flash_chk
`default_nettype wire

// file: verif/fcep_host.sv
// Serial host model sending command frames to the flash block
`timescale 1ns/1ps
`default_nettype none
module fcep_host
(
	output logic      spi_cs_n_out,
	output logic      spi_sclk_out,
	output logic      spi_si_out,
	input  wire logic spi_so_in
);
	logic [63:0] rx_q;

	initial
	begin
		spi_cs_n_out = 1'b1;
		spi_sclk_out = 1'b0;
		spi_si_out   = 1'b0;
		rx_q         = 64'h0;
	end

	// Sends the bytes, dropping cut bits at the end; serial clock idles low between frames
	task automatic frame(input logic [7:0] bq[$], input int cut);
		int n;
		logic b;
		n = bq.size() * 8 - cut;
		b = 1'b0;
		#2 spi_cs_n_out = 1'b0;
		#62.5;
		for (int i = 0; i < n; i++)
		begin
			b = bq[i / 8][7 - i % 8];
			spi_si_out = b;
			#62.5 spi_sclk_out = 1'b1;
			rx_q = {rx_q[62:0], spi_so_in};
			#62.5 spi_sclk_out = 1'b0;
		end
		#62.5 spi_cs_n_out = 1'b1;
		spi_si_out = ~b;
		#250;
	endtask : frame
endmodule : fcep_host
`default_nettype wire

// file: verif/fcep_flash_test.sv
// Self-checking bench for the flash erase/program block
`timescale 1ns/1ps
`default_nettype none
module fcep_flash_test;
	localparam int unsigned CE = 800;
	logic core_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic any_prot = 1'b0, tgt_prot = 1'b0, fail = 1'b0, clr = 1'b0, hold = 1'b0, wr_ready = 1'b0;
	logic cs_n, sclk, si, so, so_oe, erase, wr_valid, busy, write_enable_latch, ee, pe;
	logic [23:0] paddr;
	fcep_pkg::fcep_wr_word_type word;
	logic [7:0] got[int];
	logic [7:0] exp[int];
	int bad_count = 0;
	int n_tests = 0;
	int erases = 0;

	always #5 core_clk_in = ~core_clk_in;

	fcep_flash #(.PAGE_PROG_CYCLES(40), .BYTE_PROG_CYCLES(10), .CHIP_ERASE_CYCLES(CE)) uut
	(
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
		.spi_si_in(si), .spi_so_out(so), .spi_so_oe_out(so_oe), .any_block_protected_in(any_prot),
		.target_protected_in(tgt_prot), .program_addr_out(paddr), .array_fail_in(fail),
		.array_erase_out(erase), .array_wr_valid_out(wr_valid), .array_wr_ready_in(wr_ready),
		.array_wr_word_out(word), .clear_errors_in(clr), .ready_busy_flag_out(busy),
		.write_enable_latch_out(write_enable_latch), .erase_error_flag_out(ee), .program_error_flag_out(pe)
	);

	fcep_host host (.spi_cs_n_out(cs_n), .spi_sclk_out(sclk), .spi_si_out(si), .spi_so_in(so_oe ? so : ~so));

	// Array model: random stalls, records accepted words
	always @(negedge core_clk_in)
		wr_ready <= !hold && ($urandom_range(0, 3) != 0);
	always @(posedge core_clk_in)
	begin
		if (wr_valid && wr_ready)
			got[int'(word.addr)] = word.data;
		if (erase)
			erases++;
	end

	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", name, e, g);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic wen();
		host.frame('{fcep_pkg::OP_WRITE_ENABLE}, 0);
		check("wel_set", 1, write_enable_latch);
	endtask : wen

	task automatic idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 5000)
		begin
			@(negedge core_clk_in);
			k++;
		end
		check("busy_end", 0, busy);
	endtask : idle

	// Program frame with n data bytes; expects writes only when ok
	task automatic prog(input logic [23:0] a, input int n, input int cut, input bit ok);
		logic [7:0] q[$];
		logic [7:0] d;
		got.delete();
		exp.delete();
		q = '{fcep_pkg::OP_PAGE_PROGRAM, a[23:16], a[15:8], a[7:0]};
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			q.push_back(d);
			exp[{a[23:8], 8'(a[7:0] + 8'(i))}] = d;
		end
		if (!ok)
			exp.delete();
		hold = ok;
		host.frame(q, cut);
		check("prog_busy", ok, busy);
		if (ok)
		begin
			host.frame('{fcep_pkg::OP_READ_STATUS_ONE, 8'h00}, 0);
			check("status_one", 8'h03, host.rx_q[7:0]);
			check("prog_addr", a, paddr);
		end
		hold = 1'b0;
		idle();
		check("wr_count", exp.size(), got.size());
		foreach (exp[k])
			check("wr_data", exp[k], got[k]);
		check("wel_prog", 0, write_enable_latch);
	endtask : prog

	task automatic chip(input logic [7:0] op, input int cut, input bit ok);
		erases = 0;
		host.frame('{op, 8'h00}, cut);
		check("erase_busy", ok, busy);
		if (ok)
			host.frame('{fcep_pkg::OP_SUSPEND}, 0);
		if (ok)
			host.frame('{fcep_pkg::OP_ACTIVE_STATUS, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0}, 0);
		if (ok)
			check("active_status", 2'b10, {host.rx_q[40], host.rx_q[0]});
		idle();
		check("erased", ok, erases != 0);
		check("erase_len", ok ? CE + 1 : 0, erases);
		check("wel_erase", 0, write_enable_latch);
	endtask : chip

	initial
	begin
		#800000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(32'h30B1));
		repeat (4) @(negedge core_clk_in);
		rstn_in = 1'b1;
		repeat (5) @(negedge core_clk_in);
		prog(24'($urandom), 4, 0, 0);
		wen();
		prog(24'($urandom), 1, 0, 1);
		wen();
		prog({16'($urandom), 8'hFE}, 3, 0, 1);
		wen();
		prog(24'($urandom), 300, 0, 1);
		wen();
		prog(24'($urandom), 5, 3, 0);
		wen();
		prog(24'($urandom), 0, 12, 0);
		wen();
		tgt_prot = 1'b1;
		prog(24'($urandom), 2, 0, 0);
		tgt_prot = 1'b0;
		for (int r = 0; r < 3; r++)
		begin
			wen();
			prog(24'($urandom), $urandom_range(1, 20), 0, 1);
		end
		wen();
		fail = 1'b1;
		prog(24'($urandom), 2, 0, 1);
		fail = 1'b0;
		check("prog_errors", 2'b01, {ee, pe});
		@(negedge core_clk_in);
		clr = 1'b1;
		@(negedge core_clk_in);
		clr = 1'b0;
		check("errors_cleared", 2'b00, {ee, pe});
		chip(fcep_pkg::OP_CHIP_ERASE_A, 8, 0);
		wen();
		chip(fcep_pkg::OP_CHIP_ERASE_A, 8, 1);
		wen();
		fail = 1'b1;
		chip(fcep_pkg::OP_CHIP_ERASE_B, 8, 1);
		fail = 1'b0;
		check("erase_errors", 2'b11, {ee, pe});
		wen();
		chip(fcep_pkg::OP_CHIP_ERASE_A, 4, 0);
		wen();
		any_prot = 1'b1;
		chip(fcep_pkg::OP_CHIP_ERASE_B, 8, 0);
		any_prot = 1'b0;
		print_verdict();
	end
endmodule : fcep_flash_test

bind fcep_flash fcep_flash_chk #(.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)) chk
(
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .spi_cs_n_in(spi_cs_n_in), .spi_so_oe_out(spi_so_oe_out),
	.program_addr_out(program_addr_out), .array_fail_in(array_fail_in), .array_erase_out(array_erase_out),
	.array_wr_valid_out(array_wr_valid_out), .array_wr_ready_in(array_wr_ready_in),
	.array_wr_word_out(array_wr_word_out), .ready_busy_flag_out(ready_busy_flag_out),
	.write_enable_latch_out(write_enable_latch_out), .erase_error_flag_out(erase_error_flag_out),
	.program_error_flag_out(program_error_flag_out)
);
`default_nettype wire
